// >>> verilog/pec_ctrl.sv
// power enable, reset release and interrupt flag controller
// Notes on behaviour
// [RULE1] push button debounced 50 ms before use
// [RULE2] button low or power valid enables both
// [RULE3] button release turns both off unless held
// [RULE4] buck pin ORed with buck hold bit
// [RULE5] regulator pin ORed with regulator hold bit
// [RULE6] misc hold bit keeps both outputs on
// [RULE7] keep pins enable after first power-up only
// [RULE8] both off means shutdown, control off
// [RULE9] reset low during condition, released 100 ms later
// [RULE10] fixed variants: reset on bad pgood or off
// [RULE11] supervisor variant: reset from sense input
// [RULE12] flags set only for unmasked sources
// [RULE13] all sources masked after reset
// [RULE14] flags on rising edge or both edges
// [RULE15] interrupt pin low while any flag set
// [RULE16] reading flags clears them, pin releases
// [RULE17] thermal trip turns both outputs off
// [RULE18] registers default on uvlo or reset
// [RULE19] voltage codes 0.8-3.3 v, adjustable ignores
// [RULE20] io 0,1 inputs, io 2,3 led off
// [RULE21] comparator only without charge, reads 1 disabled
// [RULE22] ntc source on when mux selects temperature; code also requires charging disabled
// [RULE23] slow tick counters, debounce restarts on change
`timescale 1ns/1ps
module pec_ctrl
    import pec_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter bit SUPERVISOR  = 1'b0,
    parameter bit ADJ_BUCK    = 1'b0,
    parameter bit ADJ_REG     = 1'b0
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       ce_in,
    input  wire pec_pins_t  pins_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    output logic            buck_enable_out,
    output logic            regulator_enable_out,
    output logic            shutdown_out,
    output logic      [5:0] buck_code_out,
    output logic      [5:0] regulator_code_out,
    output logic            reset_n_out,
    output logic            reset_n_oe_out,
    output logic            irq_n_out,
    output logic            irq_n_oe_out,
    output logic      [3:0] io_out,
    output logic      [3:0] io_oe_out,
    output logic            ntc_source_out,
    output logic      [1:0] cell_limit_sel_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    pec_pins_t        sync1, sync2, pins_last;
    logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
    logic             tick;
    logic             pb_db, next_pb_db;
    logic [SLOW_W-1:0] pb_cnt, next_pb_cnt;
    logic [SLOW_W-1:0] rel_cnt, next_rel_cnt;
    logic             rst_cond;
    logic             next_reset_oe;
    logic             first_up, next_first_up;
    logic             therm_trip, next_therm_trip;
    logic             next_buck_en, next_reg_en;
    logic             buck_hold, reg_hold;
    logic [5:0]       buck_code, next_buck_code;
    logic [5:0]       reg_code, next_reg_code;
    logic             buck_hold_bit, next_buck_hold_bit;
    logic             reg_hold_bit, next_reg_hold_bit;
    logic [7:0]       misc, next_misc;
    logic [7:0]       chg_c, next_chg_c;
    logic [7:0]       chg_d, next_chg_d;
    logic [3:0]       io_level, next_io_level;
    logic [3:0]       io_dir, next_io_dir;
    logic             cmp_status, next_cmp_status;
    logic [2:0][7:0]  flags, next_flags;
    logic [2:0][7:0]  mask, next_mask;
    logic [2:0][7:0]  cond, cond_last;
    logic [2:0][7:0]  events;
    logic [2:0][7:0]  both_edge;
    logic [7:0]       next_rdata;
    logic             regs_default;
    logic             any_flag_next;

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser; pins_last sees only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1     <= PINS_IDLE;
            sync2     <= PINS_IDLE;
            pins_last <= PINS_IDLE; // no false button change after reset
        end else if (ce_in) begin
            sync1     <= pins_in;
            sync2     <= sync1;
            pins_last <= sync2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slow tick and debounce; a cheap prescaler keeps the long counters narrow
    always_comb begin
        tick          = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
        next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1); // RULE23
        next_pb_db    = pb_db;
        next_pb_cnt   = pb_cnt;
        if (sync2.push_button_n == pb_db || sync2.push_button_n != pins_last.push_button_n) begin
            next_pb_cnt = '0; // RULE23
        end else if (tick) begin
            if (pb_cnt == SLOW_W'(DEBOUNCE_TICKS - 1)) begin
                next_pb_db  = sync2.push_button_n; // RULE1
                next_pb_cnt = '0;
            end else begin
                next_pb_cnt = pb_cnt + SLOW_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt <= '0;
            pb_db    <= 1'b1;
            pb_cnt   <= '0;
        end else if (ce_in) begin
            tick_cnt <= next_tick_cnt;
            pb_db    <= next_pb_db;
            pb_cnt   <= next_pb_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power enables, thermal latch and reset release
    always_comb begin
        buck_hold       = sync2.buck_keep_on_pin | buck_hold_bit | misc[MISC_HOLD_BIT];    // RULE4 RULE6
        reg_hold        = sync2.regulator_keep_on_pin | reg_hold_bit | misc[MISC_HOLD_BIT]; // RULE5 RULE6
        next_first_up   = first_up;
        if (!sync2.battery_present) begin
            next_first_up = 1'b0; // RULE7
        end else if (!pb_db || sync2.input_power_valid) begin
            next_first_up = 1'b1;
        end
        // sensor only looks while the regulator runs; latch clears when it cools
        next_therm_trip = therm_trip ? sync2.therm_hot : (regulator_enable_out & sync2.therm_hot);
        next_buck_en    = 1'b0;
        next_reg_en     = 1'b0;
        if (sync2.system_rail_uvlo || next_therm_trip) begin
            next_buck_en = 1'b0; // RULE17
            next_reg_en  = 1'b0; // RULE17
        end else if (!pb_db || sync2.input_power_valid) begin
            next_buck_en = 1'b1; // RULE2
            next_reg_en  = 1'b1; // RULE2
        end else begin
            next_buck_en = buck_enable_out ? buck_hold : (first_up & sync2.buck_keep_on_pin);     // RULE3 RULE7
            next_reg_en  = regulator_enable_out ? reg_hold : (first_up & sync2.regulator_keep_on_pin); // RULE3 RULE7
        end
        if (SUPERVISOR) begin
            rst_cond = !sync2.sense_above; // RULE11
        end else begin
            rst_cond = !sync2.regulator_pgood || !regulator_enable_out; // RULE10
        end
        next_rel_cnt  = rel_cnt;
        next_reset_oe = reset_n_oe_out;
        if (rst_cond) begin
            next_reset_oe = 1'b1; // RULE9
            next_rel_cnt  = '0;
        end else if (reset_n_oe_out && tick) begin
            if (rel_cnt == SLOW_W'(RELEASE_TICKS - 1)) begin
                next_reset_oe = 1'b0; // RULE9
                next_rel_cnt  = '0;
            end else begin
                next_rel_cnt = rel_cnt + SLOW_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_up             <= 1'b0;
            therm_trip           <= 1'b0;
            buck_enable_out      <= 1'b0;
            regulator_enable_out <= 1'b0;
            shutdown_out         <= 1'b1;
            rel_cnt              <= '0;
            reset_n_oe_out       <= 1'b1;
            reset_n_out          <= 1'b0;
        end else if (ce_in) begin
            first_up             <= next_first_up;
            therm_trip           <= next_therm_trip;
            buck_enable_out      <= next_buck_en;
            regulator_enable_out <= next_reg_en;
            shutdown_out         <= !next_buck_en && !next_reg_en; // RULE8
            rel_cnt              <= next_rel_cnt;
            reset_n_oe_out       <= next_reset_oe;
            reset_n_out          <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file, interrupt flags and read port
    assign both_edge = {BOTH_EDGE_C, BOTH_EDGE_B, BOTH_EDGE_A};

    always_comb begin
        regs_default = reset_n_oe_out | sync2.system_rail_uvlo; // RULE18
        cond[0] = {5'h00, sync2.input_power_valid, cmp_status, !pb_db};
        cond[1] = {6'h00, sync2.regulator_pgood, sync2.therm_hot};
        cond[2] = {6'h00, sync2.io_level[1:0]};
        next_buck_code     = buck_code;
        next_reg_code      = reg_code;
        next_buck_hold_bit = buck_hold_bit;
        next_reg_hold_bit  = reg_hold_bit;
        next_misc          = misc;
        next_chg_c         = chg_c;
        next_chg_d         = chg_d;
        next_io_level      = io_level;
        next_io_dir        = io_dir;
        next_mask          = mask;
        if (wr_in) begin
            if (addr_in == ADDR_BUCK_SET) begin
                next_buck_hold_bit = wdata_in[HOLD_BIT];
                next_buck_code     = (wdata_in[5:0] > VOLT_CODE_MAX) ? VOLT_CODE_MAX : wdata_in[5:0]; // RULE19
            end else if (addr_in == ADDR_REG_SET) begin
                next_reg_hold_bit = wdata_in[HOLD_BIT];
                next_reg_code     = (wdata_in[5:0] > VOLT_CODE_MAX) ? VOLT_CODE_MAX : wdata_in[5:0]; // RULE19
            end else if (addr_in == ADDR_MISC) begin
                next_misc = wdata_in & 8'h23;
            end else if (addr_in == ADDR_CHG_C) begin
                next_chg_c = wdata_in & 8'h03;
            end else if (addr_in == ADDR_CHG_D) begin
                next_chg_d = wdata_in & 8'h03;
            end else if (addr_in == ADDR_IO_LEVEL) begin
                next_io_level = wdata_in[3:0];
            end else if (addr_in == ADDR_IO_DIR) begin
                next_io_dir = wdata_in[3:0];
            end else if (addr_in == ADDR_MASK_A) begin
                next_mask[0] = wdata_in;
            end else if (addr_in == ADDR_MASK_B) begin
                next_mask[1] = wdata_in;
            end else if (addr_in == ADDR_MASK_C) begin
                next_mask[2] = wdata_in;
            end
        end
        // comparator runs only on a primary cell, reads high when switched off
        if (!chg_c[CMP_EN_BIT]) begin
            next_cmp_status = 1'b1; // RULE21
        end else if (!chg_c[CHG_EN_BIT]) begin
            next_cmp_status = sync2.battery_below; // RULE21
        end else begin
            next_cmp_status = cmp_status;
        end
        // set wins over the read clear so a coincident event is kept
        for (int k = 0; k < 3; k++) begin
            events[k]     = (cond[k] & ~cond_last[k]) | (both_edge[k] & cond_last[k] & ~cond[k]); // RULE14
            next_flags[k] = flags[k] & ~((rd_in && addr_in == ADDR_FLAGS_A + 4'(k)) ? flags[k] : 8'h00); // RULE16
            next_flags[k] = next_flags[k] | (events[k] & ~mask[k]); // RULE12
        end
        if (regs_default) begin
            next_buck_code     = BUCK_CODE_DEF;
            next_reg_code      = REG_CODE_DEF;
            next_buck_hold_bit = 1'b0;
            next_reg_hold_bit  = 1'b0;
            next_misc          = MISC_DEF;
            next_chg_c         = CHG_C_DEF;
            next_chg_d         = CHG_D_DEF;
            next_io_level      = IO_LEVEL_DEF;
            next_io_dir        = IO_DIR_DEF; // RULE20
            next_mask          = {3{MASK_DEF}}; // RULE13
            next_flags         = '0;
        end
        any_flag_next = |next_flags;
        next_rdata = 8'h00;
        if (rd_in) begin
            if (addr_in == ADDR_BUCK_SET) begin
                next_rdata = {buck_hold_bit, 1'b0, buck_code};
            end else if (addr_in == ADDR_REG_SET) begin
                next_rdata = {reg_hold_bit, 1'b0, reg_code};
            end else if (addr_in == ADDR_MISC) begin
                next_rdata = misc | {pb_db, 7'h00};
            end else if (addr_in == ADDR_CHG_C) begin
                next_rdata = chg_c;
            end else if (addr_in == ADDR_CHG_D) begin
                next_rdata = chg_d | {cmp_status, 7'h00};
            end else if (addr_in == ADDR_IO_LEVEL) begin
                next_rdata = {4'h0, (io_level & io_dir) | (sync2.io_level & ~io_dir)};
            end else if (addr_in == ADDR_IO_DIR) begin
                next_rdata = {4'h0, io_dir};
            end else if (addr_in == ADDR_FLAGS_A) begin
                next_rdata = flags[0];
            end else if (addr_in == ADDR_FLAGS_B) begin
                next_rdata = flags[1];
            end else if (addr_in == ADDR_FLAGS_C) begin
                next_rdata = flags[2];
            end else if (addr_in == ADDR_MASK_A) begin
                next_rdata = mask[0];
            end else if (addr_in == ADDR_MASK_B) begin
                next_rdata = mask[1];
            end else if (addr_in == ADDR_MASK_C) begin
                next_rdata = mask[2];
            end
        end
    end

    // adjustable variants keep the code readable but never steer the output
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buck_code          <= BUCK_CODE_DEF;
            reg_code           <= REG_CODE_DEF;
            buck_hold_bit      <= 1'b0;
            reg_hold_bit       <= 1'b0;
            misc               <= MISC_DEF;
            chg_c              <= CHG_C_DEF;
            chg_d              <= CHG_D_DEF;
            io_level           <= IO_LEVEL_DEF;
            io_dir             <= IO_DIR_DEF;
            mask               <= {3{MASK_DEF}};
            flags              <= '0;
            cond_last          <= 24'h000002; // comparator status starts high, no false edge
            cmp_status         <= 1'b1;
            rdata_out          <= 8'h00;
            irq_n_out          <= 1'b0;
            irq_n_oe_out       <= 1'b0;
            buck_code_out      <= BUCK_CODE_DEF;
            regulator_code_out <= REG_CODE_DEF;
            io_out             <= 4'h0;
            io_oe_out          <= 4'h0;
            ntc_source_out     <= 1'b0;
            cell_limit_sel_out <= 2'h0;
        end else if (ce_in) begin
            buck_code          <= next_buck_code;
            reg_code           <= next_reg_code;
            buck_hold_bit      <= next_buck_hold_bit;
            reg_hold_bit       <= next_reg_hold_bit;
            misc               <= next_misc;
            chg_c              <= next_chg_c;
            chg_d              <= next_chg_d;
            io_level           <= next_io_level;
            io_dir             <= next_io_dir;
            mask               <= next_mask;
            flags              <= next_flags;
            cond_last          <= cond;
            cmp_status         <= next_cmp_status;
            rdata_out          <= next_rdata;
            irq_n_out          <= 1'b0;
            irq_n_oe_out       <= any_flag_next; // RULE15
            buck_code_out      <= ADJ_BUCK ? BUCK_CODE_DEF : next_buck_code; // RULE19
            regulator_code_out <= ADJ_REG ? REG_CODE_DEF : next_reg_code;    // RULE19
            io_out             <= {2'h0, next_io_level[1:0]};
            io_oe_out          <= {next_io_dir[3:2] & next_io_level[3:2], next_io_dir[1:0]}; // RULE20
            ntc_source_out     <= !next_chg_c[CHG_EN_BIT] && next_misc[MUX_EN_BIT] && next_misc[MUX_SEL_BIT]; // RULE22
            cell_limit_sel_out <= next_chg_d[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_debounce_time;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && pb_db != next_pb_db) |-> (tick && pb_cnt == SLOW_W'(DEBOUNCE_TICKS - 1));
    endproperty
    a_debounce_time: assert property (p_debounce_time) else $error("button level adopted early"); // RULE1

    property p_wake_both;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && !pb_db && !sync2.system_rail_uvlo && !sync2.therm_hot) |=>
            (buck_enable_out && regulator_enable_out);
    endproperty
    a_wake_both: assert property (p_wake_both) else $error("pressed button did not enable both"); // RULE2

    property p_thermal_off;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && regulator_enable_out && sync2.therm_hot) |=> (!buck_enable_out && !regulator_enable_out);
    endproperty
    a_thermal_off: assert property (p_thermal_off) else $error("thermal trip left an output on"); // RULE17

    property p_reset_hold;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && rst_cond) |=> reset_n_oe_out;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset not driven during condition"); // RULE9

    property p_release_delay;
        @(posedge clk_in) disable iff (!rstn_in)
        $fell(reset_n_oe_out) |-> ($past(rel_cnt) == SLOW_W'(RELEASE_TICKS - 1) && $past(tick));
    endproperty
    a_release_delay: assert property (p_release_delay) else $error("reset released before delay"); // RULE9

    property p_masked_at_start;
        @(posedge clk_in) $rose(rstn_in) |-> (mask == {3{MASK_DEF}});
    endproperty
    a_masked_at_start: assert property (p_masked_at_start) else $error("sources unmasked after reset"); // RULE13

    property p_irq_pin;
        @(posedge clk_in) disable iff (!rstn_in)
        ce_in |=> (irq_n_oe_out == (|flags));
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin disagrees with flags"); // RULE15

    property p_read_clear;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && rd_in && addr_in == ADDR_FLAGS_A && events[0] == 8'h00) |=> (flags[0] == 8'h00);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag read did not clear"); // RULE16

    property p_cmp_disabled;
        @(posedge clk_in) disable iff (!rstn_in)
        (ce_in && !chg_c[CMP_EN_BIT]) |=> cmp_status;
    endproperty
    a_cmp_disabled: assert property (p_cmp_disabled) else $error("comparator status low while off"); // RULE21

endmodule

// >>> verilog/pec_pkg.sv
// constants, register map and pin bundle of the power enable, reset and interrupt controller
package pec_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TICK_TIME_US    = 1000;
    localparam int TICK_CYCLES_DEF = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_MS     = 50;
    localparam int RELEASE_MS      = 100;
    localparam int DEBOUNCE_TICKS  = (DEBOUNCE_MS * 1000 + TICK_TIME_US - 1) / TICK_TIME_US;
    localparam int RELEASE_TICKS   = (RELEASE_MS * 1000 + TICK_TIME_US - 1) / TICK_TIME_US;
    localparam int TICK_W          = 24;
    localparam int SLOW_W          = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [3:0] ADDR_BUCK_SET = 4'h0;
    localparam logic [3:0] ADDR_REG_SET  = 4'h1;
    localparam logic [3:0] ADDR_MISC     = 4'h2;
    localparam logic [3:0] ADDR_CHG_C    = 4'h3;
    localparam logic [3:0] ADDR_CHG_D    = 4'h4;
    localparam logic [3:0] ADDR_IO_LEVEL = 4'h5;
    localparam logic [3:0] ADDR_IO_DIR   = 4'h6;
    localparam logic [3:0] ADDR_FLAGS_A  = 4'h7;
    localparam logic [3:0] ADDR_FLAGS_B  = 4'h8;
    localparam logic [3:0] ADDR_FLAGS_C  = 4'h9;
    localparam logic [3:0] ADDR_MASK_A   = 4'ha;
    localparam logic [3:0] ADDR_MASK_B   = 4'hb;
    localparam logic [3:0] ADDR_MASK_C   = 4'hc;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int HOLD_BIT      = 7;
    localparam int MISC_HOLD_BIT = 5;
    localparam int MISC_PB_BIT   = 7;
    localparam int MUX_EN_BIT    = 1;
    localparam int MUX_SEL_BIT   = 0;
    localparam int CHG_EN_BIT    = 0;
    localparam int CMP_EN_BIT    = 1;
    localparam int CMP_STAT_BIT  = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and code range (0.8 v .. 3.3 v in 100 mv steps)
    localparam logic [5:0] VOLT_CODE_MAX  = 6'h19;
    localparam logic [5:0] BUCK_CODE_DEF  = 6'h0b;
    localparam logic [5:0] REG_CODE_DEF   = 6'h0b;
    localparam logic [7:0] MISC_DEF       = 8'h00;
    localparam logic [7:0] CHG_C_DEF      = 8'h00;
    localparam logic [7:0] CHG_D_DEF      = 8'h00;
    localparam logic [3:0] IO_LEVEL_DEF   = 4'h0;
    localparam logic [3:0] IO_DIR_DEF     = 4'hc;
    localparam logic [7:0] MASK_DEF       = 8'hff;
    localparam logic [7:0] BOTH_EDGE_A    = 8'h05;
    localparam logic [7:0] BOTH_EDGE_B    = 8'h02;
    localparam logic [7:0] BOTH_EDGE_C    = 8'h03;

    ////////////////////////////////////////////////////////////////////////////////
    // pin bundle, all asynchronous to clk_in
    typedef struct packed {
        logic       push_button_n;
        logic       buck_keep_on_pin;
        logic       regulator_keep_on_pin;
        logic       input_power_valid;
        logic       therm_hot;
        logic       regulator_pgood;
        logic       sense_above;
        logic       battery_below;
        logic       system_rail_uvlo;
        logic       battery_present;
        logic [3:0] io_level;
    } pec_pins_t;

    // idle pin levels after reset: button released, everything else low
    localparam pec_pins_t PINS_IDLE = 14'h2000;

endpackage

// >>> testbench/pec_far_side_model.sv
// far side model: push button with pull-up, pulled-up reset and interrupt lines
`timescale 1ns/1ps
module pec_far_side_model (
    input  wire logic press_in,
    input  wire logic reset_n_oe_in,
    input  wire logic irq_n_oe_in,
    output logic      push_button_n_out,
    output logic      reset_line_out,
    output logic      irq_line_out
);
    // open switch leaves the pull-up, so released reads high
    assign push_button_n_out = !press_in;
    // open-drain lines float up through the external pull-ups
    assign reset_line_out = !reset_n_oe_in;
    assign irq_line_out   = !irq_n_oe_in;
endmodule

// >>> testbench/pec_ctrl_tb_top.sv
// self-checking bench of the power enable, reset and interrupt controller
`timescale 1ns/1ps
module pec_ctrl_tb_top import pec_pkg::*;;
    logic       clk_in, rstn_in, wr, rd, press, pb_n, rst_l, irq_l, buck, regu, shut, r_oe, i_oe, ce, ntc;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    pec_pins_t  pins, pins_dut;
    int         bad_count, n_checks, cycles;
    // button level comes from the far side model
    always_comb begin
        pins_dut = pins;
        pins_dut.push_button_n = pb_n;
    end
    // short tick keeps debounce at 200 cycles and release at 400
    pec_ctrl #(.TICK_CYCLES(4)) pec_ctrl_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .pins_in(pins_dut), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .buck_enable_out(buck), .regulator_enable_out(regu), .shutdown_out(shut), .buck_code_out(),
        .regulator_code_out(), .reset_n_out(), .reset_n_oe_out(r_oe), .irq_n_out(), .irq_n_oe_out(i_oe),
        .io_out(), .io_oe_out(), .ntc_source_out(ntc), .cell_limit_sel_out());
    pec_far_side_model far_inst (.press_in(press), .reset_n_oe_in(r_oe), .irq_n_oe_in(i_oe),
        .push_button_n_out(pb_n), .reset_line_out(rst_l), .irq_line_out(irq_l));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a; rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rd_reg(ADDR_MASK_A, MASK_DEF);
        rd_reg(ADDR_IO_DIR, {4'h0, IO_DIR_DEF});
        rd_reg(ADDR_CHG_D, 8'h80);
        chk({rst_l, irq_l}, 8'h01);
    endtask
    task automatic t_press();
        press <= 1'b1;
        wt(150);
        chk({buck, regu}, 8'h00);
        for (int i = 0; i < 100 && buck !== 1'b1; i++) wt(1);
        chk({buck, regu}, 8'h03);
        pins.regulator_pgood <= 1'b1;
        wt(350);
        chk(rst_l, 8'h00);
        for (int i = 0; i < 100 && rst_l !== 1'b1; i++) wt(1);
        chk(rst_l, 8'h01);
    endtask
    task automatic t_irq();
        wr_reg(ADDR_MASK_A, 8'hfb);
        pins.io_level[0] <= 1'b1;
        wt(6);
        chk(irq_l, 8'h01);
        pins.io_level[0] <= 1'b0;
        pins.input_power_valid <= 1'b1;
        wt(6);
        chk(irq_l, 8'h00);
        rd_reg(ADDR_FLAGS_A, 8'h04);
        wt(1);
        chk(irq_l, 8'h01);
        wr_reg(ADDR_BUCK_SET, 8'h3f);
        rd_reg(ADDR_BUCK_SET, {2'h0, VOLT_CODE_MAX});
        wr_reg(ADDR_CHG_C, 8'h02);
        rd_reg(ADDR_CHG_D, 8'h00);
        wr_reg(ADDR_MISC, 8'h23);
        wt(1);
        chk(ntc, 8'h01);
    endtask
    task automatic t_hold();
        pins.input_power_valid <= 1'b0;
        pins.buck_keep_on_pin <= 1'b1;
        press <= 1'b0;
        wt(260);
        chk({buck, regu, rst_l}, 8'h07);
        rd_reg(ADDR_MISC, 8'ha3);
        wr_reg(ADDR_MISC, 8'h00);
        wt(6);
        chk({buck, regu, rst_l}, 8'h04);
        rd_reg(ADDR_MASK_A, MASK_DEF);
        pins.buck_keep_on_pin <= 1'b0;
        wt(6);
        chk({buck, shut}, 8'h01);
        pins.buck_keep_on_pin <= 1'b1;
        wt(6);
        chk(buck, 8'h01);
    endtask
    task automatic t_thermal();
        pins.input_power_valid <= 1'b1;
        wt(6);
        chk({buck, regu}, 8'h03);
        ce <= 1'b0;
        pins.therm_hot <= 1'b1;
        wt(6);
        chk({buck, regu}, 8'h03);
        ce <= 1'b1;
        wt(6);
        chk({buck, regu}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // hang guard well above the roughly 950 cycles of the run
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        {rstn_in, wr, rd, press, addr, wdata, pins} = '0;
        {bad_count, n_checks, cycles} = '0;
        pins.battery_present = 1'b1;
        ce = 1'b1;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_defaults();
        t_press();
        t_irq();
        t_hold();
        t_thermal();
        summarize();
    end
endmodule
